// ---- rtl/tof_flags.sv ----
`timescale 1ns/1ps
`include "tof_params.svh"
module tof_flags
    import tof_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire tof_req_t   req,
    input  wire logic [4:0] severe_temp_event,
    input  wire logic [4:0] warning_temp_event,
    input  wire logic [2:0] overcurrent_event,
    output logic      [7:0] rdata
);
    // ==========================================================
    // Decode helpers.
    function automatic logic write_hit(input tof_req_t   r,
                                       input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : write_hit

    function automatic logic [7:0] clear_mask(input tof_req_t   r,
                                              input logic [7:0] a);
        return write_hit(r, a) ? r.wdata : 8'h00;
    endfunction : clear_mask

    function automatic logic [7:0] sticky_next(input logic [7:0] flags,
                                               input logic [7:0] clr,
                                               input logic [7:0] ev);
        return (flags & ~clr) | ev;
    endfunction : sticky_next

    // ==========================================================
    // Flag registers.
    logic [4:0] thermal_shutdown_flags;
    logic [4:0] thermal_warning_flags;
    logic [2:0] lowside_overcurrent_flags;
    logic [4:0] next_shutdown;
    logic [4:0] next_warning;
    logic [2:0] next_overcur;
    logic [7:0] next_rdata;
    logic [7:0] mask_sd;
    logic [7:0] mask_wn;
    logic [7:0] mask_oc;
    logic [4:0] clr_sd;
    logic [4:0] clr_wn;
    logic [2:0] clr_oc;
    logic [7:0] wide_sd;
    logic [7:0] wide_wn;
    logic [7:0] wide_oc;

    // ==========================================================
    // Severe temperature flags.
    always_comb begin
        mask_sd       = clear_mask(req, `TOF_ADDR_SHUTDOWN);
        clr_sd        = mask_sd[4:0];
        wide_sd       = sticky_next({3'h0, thermal_shutdown_flags}, {3'h0, clr_sd},
                                    {3'h0, severe_temp_event});
        next_shutdown = wide_sd[4:0];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            thermal_shutdown_flags <= 5'h00;
        end else begin
            thermal_shutdown_flags <= next_shutdown;
        end
    end

    // ==========================================================
    // Warning temperature flags.
    always_comb begin
        mask_wn      = clear_mask(req, `TOF_ADDR_WARNING);
        clr_wn       = mask_wn[4:0];
        wide_wn      = sticky_next({3'h0, thermal_warning_flags}, {3'h0, clr_wn},
                                   {3'h0, warning_temp_event});
        next_warning = wide_wn[4:0];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            thermal_warning_flags <= 5'h00;
        end else begin
            thermal_warning_flags <= next_warning;
        end
    end

    // ==========================================================
    // Low-side overcurrent flags.
    always_comb begin
        mask_oc      = clear_mask(req, `TOF_ADDR_OVERCUR);
        clr_oc       = mask_oc[2:0];
        wide_oc      = sticky_next({5'h00, lowside_overcurrent_flags}, {5'h00, clr_oc},
                                   {5'h00, overcurrent_event});
        next_overcur = wide_oc[2:0];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lowside_overcurrent_flags <= 3'h0;
        end else begin
            lowside_overcurrent_flags <= next_overcur;
        end
    end

    // ==========================================================
    // Read data.
    always_comb begin
        case (req.addr)
            `TOF_ADDR_SHUTDOWN: next_rdata = {3'h0, next_shutdown};
            `TOF_ADDR_WARNING:  next_rdata = {3'h0, next_warning};
            `TOF_ADDR_OVERCUR:  next_rdata = {5'h00, next_overcur};
            default:            next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata <= `TOF_RESET_VALUE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Assertions.
    sequence sd_clear_s;
        write_hit(req, `TOF_ADDR_SHUTDOWN) && req.wdata[0] && !severe_temp_event[0];
    endsequence

    sequence oc_clear_s;
        write_hit(req, `TOF_ADDR_OVERCUR) && req.wdata[0] && !overcurrent_event[0];
    endsequence

    sequence wn_clear_s;
        write_hit(req, `TOF_ADDR_WARNING) && req.wdata[0] && !warning_temp_event[0];
    endsequence

    sequence wn_set_wins_s;
        write_hit(req, `TOF_ADDR_WARNING) && req.wdata[0] && warning_temp_event[0];
    endsequence

    sequence sd_keep_s;
        write_hit(req, `TOF_ADDR_SHUTDOWN) && !req.wdata[4] && thermal_shutdown_flags[4];
    endsequence

    sequence wn_rsvd_write_s;
        write_hit(req, `TOF_ADDR_WARNING) && (req.wdata[4:0] == 5'h00);
    endsequence

    sticky_severe_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        severe_temp_event[0] |=> thermal_shutdown_flags[0])
        else $error("severe flag did not set");

    sticky_warn_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        warning_temp_event[4] |=> thermal_warning_flags[4])
        else $error("warning flag did not set");

    sticky_oc_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        overcurrent_event[2] |=> lowside_overcurrent_flags[2])
        else $error("overcurrent flag did not set");

    severe_all_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        |severe_temp_event |=> (thermal_shutdown_flags & $past(severe_temp_event))
        == $past(severe_temp_event))
        else $error("severe flags did not all set");

    warn_all_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        |warning_temp_event |=> (thermal_warning_flags & $past(warning_temp_event))
        == $past(warning_temp_event))
        else $error("warning flags did not all set");

    oc_all_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        |overcurrent_event |=> (lowside_overcurrent_flags & $past(overcurrent_event))
        == $past(overcurrent_event))
        else $error("overcurrent flags did not all set");

    hold_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        thermal_warning_flags[2] && !(req.wr && req.addr == `TOF_ADDR_WARNING
        && req.wdata[2]) |=> thermal_warning_flags[2])
        else $error("flag dropped without clear");

    w1c_oc_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        oc_clear_s |=> !lowside_overcurrent_flags[0])
        else $error("overcurrent clear failed");

    w1c_sd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sd_clear_s |=> !thermal_shutdown_flags[0])
        else $error("severe clear failed");

    w1c_wn_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        wn_clear_s |=> !thermal_warning_flags[0])
        else $error("warning clear failed");

    clear_only_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sd_keep_s |=> thermal_shutdown_flags[4])
        else $error("unwritten flag was cleared");

    set_wins_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        wn_set_wins_s |=> thermal_warning_flags[0])
        else $error("clear beat a new event");

    read_wn_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        req.addr == `TOF_ADDR_WARNING |=> rdata == {3'h0, thermal_warning_flags})
        else $error("warning readback wrong");

    read_sd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        req.addr == `TOF_ADDR_SHUTDOWN |=> rdata == {3'h0, thermal_shutdown_flags})
        else $error("severe readback wrong");

    read_oc_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        req.addr == `TOF_ADDR_OVERCUR |=> rdata == {5'h00, lowside_overcurrent_flags})
        else $error("overcurrent readback wrong");

    rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $past(req.addr) == `TOF_ADDR_OVERCUR |-> rdata[7:3] == 5'h00)
        else $error("reserved bits not zero");

    rsvd_ignore_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        wn_rsvd_write_s |=> thermal_warning_flags
        == ($past(thermal_warning_flags) | $past(warning_temp_event)))
        else $error("reserved write changed flags");

    unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(req.addr inside {`TOF_ADDR_SHUTDOWN, `TOF_ADDR_WARNING, `TOF_ADDR_OVERCUR})
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : tof_flags

// ---- rtl/tof_params.svh ----
// Function
// - Five sticky severe temperature flags, bits 4..0, set when sensor exceeds threshold.
// - Set flags stay until host writes 1; only bits written 1 clear.
// - Warning temperature byte sits at offset b5, resets to zero.
// - Five sticky warning temperature flags, same bit order, set above warning threshold.
// - Low-side overcurrent byte sits at offset b6, resets to zero.
// - Sticky overcurrent flags: bit 2 controller six, 1 two, 0 one.
// - Severe temperature byte sits at offset b4, just below the warning byte.
`ifndef TOF_PARAMS_SVH
`define TOF_PARAMS_SVH
`define TOF_ADDR_SHUTDOWN 8'hb4
`define TOF_ADDR_WARNING  8'hb5
`define TOF_ADDR_OVERCUR  8'hb6
`define TOF_RESET_VALUE   8'h00
`define TOF_THERM_BITS    5
`define TOF_OC_BITS       3
`endif

// ---- rtl/tof_pkg.sv ----
package tof_pkg;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tof_req_t;
endpackage : tof_pkg

// ---- tb/thermal_overcurrent_fault_flags_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: %h %h", $time, g, e); end end
module thermal_overcurrent_fault_flags_tb
    import tof_pkg::*;
;
    logic       clk_sys    = 1'b0;
    logic       resetn     = 1'b0;
    logic [4:0] sev        = '0;
    logic [4:0] warn       = '0;
    logic [2:0] oc         = '0;
    tof_req_t   req;
    logic [7:0] rdata;
    logic [7:0] d;
    int         mismatches = 0;
    int         cmp_count  = 0;
    always #50 clk_sys = ~clk_sys;
    tof_flags i_tof_flags (.clk_sys(clk_sys), .resetn(resetn), .req(req),
        .severe_temp_event(sev), .warning_temp_event(warn), .overcurrent_event(oc),
        .rdata(rdata));
    tof_host i_tof_host (.clk_sys(clk_sys), .req(req), .rdata(rdata));
    task automatic print_verdict;
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic reset_values;
        i_tof_host.rd(8'hb4, d); `CHK(d, 8'h00)
        i_tof_host.rd(8'hb5, d); `CHK(d, 8'h00)
        i_tof_host.rd(8'hb6, d); `CHK(d, 8'h00)
    endtask : reset_values
    task automatic sticky_set;
        @(posedge clk_sys) {sev, warn, oc} <= {5'h1f, 5'h15, 3'h7};
        @(posedge clk_sys) {sev, warn, oc} <= '0;
        i_tof_host.rd(8'hb4, d); `CHK(d, 8'h1f)
        i_tof_host.rd(8'hb5, d); `CHK(d, 8'h15)
        i_tof_host.rd(8'hb6, d); `CHK(d, 8'h07)
    endtask : sticky_set
    task automatic clear_ones;
        i_tof_host.wr(8'hb4, 8'h01);
        i_tof_host.rd(8'hb4, d); `CHK(d, 8'h1e)
        i_tof_host.wr(8'hb5, 8'he0);
        i_tof_host.rd(8'hb5, d); `CHK(d, 8'h15)
        i_tof_host.wr(8'hb6, 8'hff);
        i_tof_host.rd(8'hb6, d); `CHK(d, 8'h00)
        i_tof_host.rd(8'hb7, d); `CHK(d, 8'h00)
    endtask : clear_ones
    task automatic set_wins;
        @(posedge clk_sys) warn <= 5'h01;
        i_tof_host.wr(8'hb5, 8'h01);
        i_tof_host.rd(8'hb5, d);
        `CHK(d, 8'h15)
        @(posedge clk_sys) warn <= '0;
        i_tof_host.wr(8'hb5, 8'h01);
        i_tof_host.rd(8'hb5, d);
        `CHK(d, 8'h14)
    endtask : set_wins
    task automatic reset_midrun;
        @(posedge clk_sys) oc <= 3'h7;
        @(posedge clk_sys) oc <= '0;
        i_tof_host.rd(8'hb6, d);
        `CHK(d, 8'h07)
        @(posedge clk_sys) resetn <= 1'b0;
        @(posedge clk_sys) resetn <= 1'b1;
        i_tof_host.rd(8'hb4, d);
        `CHK(d, 8'h00)
        i_tof_host.rd(8'hb5, d);
        `CHK(d, 8'h00)
        i_tof_host.rd(8'hb6, d);
        `CHK(d, 8'h00)
    endtask : reset_midrun
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        reset_values();
        sticky_set();
        clear_ones();
        set_wins();
        reset_midrun();
        print_verdict();
    end
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule : thermal_overcurrent_fault_flags_tb

// ---- tb/tof_host.sv ----
`timescale 1ns/1ps
module tof_host
    import tof_pkg::*;
(
    input  wire logic       clk_sys,
    output tof_req_t        req,
    input  wire logic [7:0] rdata
);
    initial req = '0;
    // Write strobe stands one cycle; 1 bits clear flags.
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk_sys) req <= '{wr: 1'b1, addr: a, wdata: w};
        @(posedge clk_sys) req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge clk_sys) req.addr <= a;
        @(posedge clk_sys) #1 r = rdata;
    endtask : rd
endmodule : tof_host
